// *** verilog/hall_commutation_decoder.sv ***
// hall_commutation_decoder: hall filter, six-step decoder and register file
// assumes: APB master on clk, hall pins and comparators asynchronous to clk,
// external delay circuit and timers return the delayed phases on delayed_phase
`timescale 1ns/1ps
`default_nettype none

// Contract
// - decoder enabled, no brake, forward: drive pattern from entries zero to five.
// - decoder enabled, no brake, backward: drive pattern from entries six to eleven.
// - phase state selects entry; sequence differs for 60 and 120 degree modes.
// - brake forces high sides off and low sides on, overriding everything.
// - decoder disabled without brake drives all six outputs low.
// - angle bit 0 selects 60 degree, 1 selects 120; resets to 1.
// - input mode 0 uses software phase bits, 1 uses filtered phases.
// - source select routes hall pins (0) or comparator outputs (1) to filter.
// - each filtered phase raises interrupt per 2-bit edge field.
// - 2-bit field selects timer for hall delay; code 11 unused.
// - delay path bit routes phases directly (0) or through delay circuit (1).
// - soft phase register holds A, B, C in bits 0..2; rest zero.
// - table entry bits 5..0: A high, A low, B high, B low, C high, C low.
// - 5-bit check count, reset zero, sets consecutive samples before accepting.
// - filter enable 0 bypasses filter with raw phases; 1 filters.
// - filter sample clock is sysclk over 2 to 128; code 111 unused.
// - unimplemented register bits ignore writes and read zero.
// - filter delay equals check count times sampling period.
module hall_commutation_decoder #(
	parameter int unsigned COUNT_W = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] hall_pin,
	input wire logic [2:0] comparator_out,
	input wire logic [2:0] delayed_phase,
	output logic [2:0] filtered_phase,
	output logic [2:0] phase_irq,
	output logic [2:0] delay_timer_enable,
	output logic delay_path_select,
	output hall_pkg::gate_t gate
);
	// elaboration checks: the decode below is written for these sizes and codes
	if (COUNT_W != 5) begin : g_count_w
		$error("check count field must be five bits wide");
	end
	if (hall_pkg::TABLE_ENTRIES != 12) begin : g_entries
		$error("pattern table must hold twelve entries");
	end
	if (hall_pkg::BACKWARD_BASE != 6) begin : g_backward
		$error("backward half must start at entry six");
	end
	if (hall_pkg::MASK_CHECK_COUNT != 8'h1F) begin : g_count_mask
		$error("check count mask must match the count width");
	end
	if (hall_pkg::RST_DECODER_CTRL[hall_pkg::BIT_ANGLE] != 1'b1) begin : g_angle_reset
		$error("decoder control must reset to the 120 degree sequence");
	end
	if (hall_pkg::PATTERN_BRAKE != 6'h15) begin : g_brake_pattern
		$error("brake pattern must keep high sides off and low sides on");
	end
	if (hall_pkg::PATTERN_OFF != 6'h00) begin : g_off_pattern
		$error("off pattern must keep all six gates off");
	end
	if (hall_pkg::FILTER_CLK_UNUSED != 3'h7) begin : g_unused_clock
		$error("unused filter clock code must be 111");
	end
	// every register takes one aligned word
	if (hall_pkg::OFS_SOURCE_EDGE[1:0] != 2'h0) begin : g_align_source
		$error("register offsets must be word aligned");
	end
	if (hall_pkg::OFS_DECODER_CTRL[1:0] != 2'h0) begin : g_align_decoder
		$error("register offsets must be word aligned");
	end
	if (hall_pkg::OFS_SOFT_PHASE[1:0] != 2'h0) begin : g_align_soft
		$error("register offsets must be word aligned");
	end
	if (hall_pkg::OFS_CHECK_COUNT[1:0] != 2'h0) begin : g_align_count
		$error("register offsets must be word aligned");
	end
	if (hall_pkg::OFS_FILTER_MODE[1:0] != 2'h0) begin : g_align_filter
		$error("register offsets must be word aligned");
	end
	if (hall_pkg::OFS_STATUS[1:0] != 2'h0) begin : g_align_status
		$error("register offsets must be word aligned");
	end
	if (hall_pkg::OFS_TABLE_BASE[1:0] != 2'h0) begin : g_align_table
		$error("register offsets must be word aligned");
	end
	// table decode assumes no single register sits among the entries
	if (hall_pkg::OFS_TABLE_BASE <= hall_pkg::OFS_STATUS) begin : g_table_place
		$error("pattern table must sit above the single registers");
	end

	typedef struct packed {
		hall_pkg::config_t cfg;
		logic [hall_pkg::TABLE_ENTRIES-1:0][5:0] table_e;
		logic [2:0] pin_s1;
		logic [2:0] pin_s2;
		logic [2:0] cmp_s1;
		logic [2:0] cmp_s2;
		logic [2:0] filt;
		logic [2:0] filt_prev;
		logic [2:0][COUNT_W-1:0] hold_cnt;
		logic [6:0] div_cnt;
		logic [2:0] irq;
		logic [31:0] rdata;
		hall_pkg::gate_t gate;
	} state_t;

	state_t s_q;
	state_t s_d;

	// returns {valid, index 0..5}; abc is {A,B,C}; invalid states give valid 0
	function automatic logic [3:0] entry_index(input logic [2:0] abc, input logic angle_120);
		logic [3:0] r;
		r = 4'h0;
		if (angle_120) begin
			case (abc)
				3'h4: r = 4'h8;
				3'h6: r = 4'h9;
				3'h2: r = 4'hA;
				3'h3: r = 4'hB;
				3'h1: r = 4'hC;
				3'h5: r = 4'hD;
				default: r = 4'h0;
			endcase
		end else begin
			case (abc)
				3'h4: r = 4'h8;
				3'h6: r = 4'h9;
				3'h7: r = 4'hA;
				3'h3: r = 4'hB;
				3'h1: r = 4'hC;
				3'h0: r = 4'hD;
				default: r = 4'h0;
			endcase
		end
		return r;
	endfunction

	// code 111 gives no sample instants, so the filter holds its level
	function automatic logic sample_tick(input logic [6:0] cnt, input logic [2:0] sel);
		logic [6:0] m;
		m = 7'h00;
		case (sel)
			3'h0: m = 7'h01;
			3'h1: m = 7'h03;
			3'h2: m = 7'h07;
			3'h3: m = 7'h0F;
			3'h4: m = 7'h1F;
			3'h5: m = 7'h3F;
			3'h6: m = 7'h7F;
			default: m = 7'h00;
		endcase
		return ((cnt & m) == m) && (sel != hall_pkg::FILTER_CLK_UNUSED);
	endfunction

	// table entry decode, shared by the write and read paths; {hit, index}
	function automatic logic [4:0] table_slot(input logic [11:0] addr);
		logic [4:0] r;
		r = 5'h00;
		for (int n = 0; n < hall_pkg::TABLE_ENTRIES; n++) begin
			if (addr == hall_pkg::OFS_TABLE_BASE + 12'(4 * n)) begin
				r = {1'b1, 4'(n)};
			end
		end
		return r;
	endfunction

	// edge test of a filtered level against its value one clock earlier
	function automatic logic edge_hit(input logic [1:0] mode, input logic now, input logic was);
		logic r;
		r = 1'b0;
		case (mode)
			hall_pkg::EDGE_RISE: r = now && !was;
			hall_pkg::EDGE_FALL: r = !now && was;
			hall_pkg::EDGE_BOTH: r = now != was;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// priority brake, invalid state, disabled, table
	function automatic logic [5:0] gate_pattern(input logic brake, input logic enable,
		input logic valid, input logic [5:0] entry_bits);
		logic [5:0] r;
		r = hall_pkg::PATTERN_OFF;
		if (brake) begin
			r = hall_pkg::PATTERN_BRAKE;
		end else if (!valid) begin
			r = hall_pkg::PATTERN_OFF;
		end else if (!enable) begin
			r = hall_pkg::PATTERN_OFF;
		end else begin
			r = entry_bits;
		end
		return r;
	endfunction

	logic [2:0] raw_phase;
	logic [2:0] decode_in;
	logic [2:0] abc;
	logic [3:0] idx;
	logic tick;
	logic wr;
	logic [7:0] wbyte;
	logic [5:0] entry;
	logic [3:0] tsel;
	logic [4:0] slot;

	always_comb begin
		s_d = s_q;
		wr = psel && penable && pwrite;
		wbyte = pwdata[7:0];
		tsel = 4'h0;
		entry = hall_pkg::PATTERN_OFF;
		// two-flop synchronisers on both sources; the select acts after them
		// so no logic sits in front of a first-stage flop
		s_d.pin_s1 = hall_pin;
		s_d.pin_s2 = s_q.pin_s1;
		s_d.cmp_s1 = comparator_out;
		s_d.cmp_s2 = s_q.cmp_s1;
		if (s_q.cfg.source_edge[hall_pkg::BIT_SOURCE_SEL]) begin
			raw_phase = s_q.cmp_s2;
		end else begin
			raw_phase = s_q.pin_s2;
		end
		// divider runs always; tick marks sample instants
		s_d.div_cnt = s_q.div_cnt + 7'h01;
		tick = sample_tick(s_q.div_cnt, s_q.cfg.filter_mode[2:0]);
		for (int i = 0; i < 3; i++) begin
			if (!s_q.cfg.filter_mode[hall_pkg::BIT_FILTER_ENABLE]) begin
				s_d.filt[i] = raw_phase[i];
				s_d.hold_cnt[i] = '0;
			end else if (tick) begin
				// accept only after count equal samples
				// delay is count times sampling period
				if (raw_phase[i] == s_q.filt[i]) begin
					s_d.hold_cnt[i] = '0;
				end else if (s_q.hold_cnt[i] + 1'b1 >= s_q.cfg.check_count[COUNT_W-1:0]) begin
					s_d.filt[i] = raw_phase[i];
					s_d.hold_cnt[i] = '0;
				end else begin
					s_d.hold_cnt[i] = s_q.hold_cnt[i] + 1'b1;
				end
			end
		end
		s_d.filt_prev = s_q.filt;
		for (int i = 0; i < 3; i++) begin
			// edge field per phase, one-cycle pulse
			s_d.irq[i] = edge_hit(s_q.cfg.source_edge[2*i +: 2], s_q.filt[i], s_q.filt_prev[i]);
		end
		decode_in = s_q.cfg.decoder_ctrl[hall_pkg::BIT_DELAY_PATH] ? delayed_phase : s_q.filt;
		// software or hall phases; bit order A=0
		if (!s_q.cfg.decoder_ctrl[hall_pkg::BIT_INPUT_MODE]) begin
			decode_in = s_q.cfg.soft_phase[2:0];
		end
		abc = {decode_in[0], decode_in[1], decode_in[2]};
		idx = entry_index(abc, s_q.cfg.decoder_ctrl[hall_pkg::BIT_ANGLE]);
		// forward or backward half of the table
		tsel = {1'b0, idx[2:0]} + (s_q.cfg.decoder_ctrl[hall_pkg::BIT_DIRECTION] ?
			4'(hall_pkg::BACKWARD_BASE) : 4'h0);
		if (idx[3]) begin
			entry = s_q.table_e[tsel];
		end
		s_d.gate = gate_pattern(s_q.cfg.decoder_ctrl[hall_pkg::BIT_BRAKE],
			s_q.cfg.decoder_ctrl[hall_pkg::BIT_DECODER_ENABLE], idx[3], entry);
		slot = table_slot(paddr);
		// masks drop unimplemented bits on write
		if (wr) begin
			case (paddr)
				hall_pkg::OFS_SOURCE_EDGE: begin
					s_d.cfg.source_edge = wbyte & hall_pkg::MASK_SOURCE_EDGE;
				end
				hall_pkg::OFS_DECODER_CTRL: begin
					s_d.cfg.decoder_ctrl = wbyte;
				end
				hall_pkg::OFS_SOFT_PHASE: begin
					s_d.cfg.soft_phase = wbyte & hall_pkg::MASK_SOFT_PHASE;
				end
				hall_pkg::OFS_CHECK_COUNT: begin
					s_d.cfg.check_count = wbyte & hall_pkg::MASK_CHECK_COUNT;
				end
				hall_pkg::OFS_FILTER_MODE: begin
					s_d.cfg.filter_mode = wbyte & hall_pkg::MASK_FILTER_MODE;
				end
				default: begin
					if (slot[4]) begin
						s_d.table_e[slot[3:0]] = wbyte[5:0];
					end
				end
			endcase
		end
		// read data registered in setup phase, shown in access phase
		s_d.rdata = 32'h0000_0000;
		case (paddr)
			hall_pkg::OFS_SOURCE_EDGE: begin
				s_d.rdata[7:0] = s_q.cfg.source_edge;
			end
			hall_pkg::OFS_DECODER_CTRL: begin
				s_d.rdata[7:0] = s_q.cfg.decoder_ctrl;
			end
			hall_pkg::OFS_SOFT_PHASE: begin
				s_d.rdata[7:0] = s_q.cfg.soft_phase;
			end
			hall_pkg::OFS_CHECK_COUNT: begin
				s_d.rdata[7:0] = s_q.cfg.check_count;
			end
			hall_pkg::OFS_FILTER_MODE: begin
				s_d.rdata[7:0] = s_q.cfg.filter_mode;
			end
			hall_pkg::OFS_STATUS: begin
				s_d.rdata[8:0] = {s_q.gate, s_q.filt};
			end
			default: begin
				if (slot[4]) begin
					s_d.rdata[5:0] = s_q.table_e[slot[3:0]];
				end
			end
		endcase
		if (rst) begin
			s_d = '0;
			s_d.cfg.decoder_ctrl = hall_pkg::RST_DECODER_CTRL;
		end
	end

	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	// one-hot enable toward the chosen timer, only while delay path is on
	always_comb begin
		delay_timer_enable = 3'h0;
		if (s_q.cfg.decoder_ctrl[hall_pkg::BIT_DELAY_PATH]) begin
			case (s_q.cfg.decoder_ctrl[hall_pkg::POS_TIMER_SEL +: 2])
				hall_pkg::TMR_ZERO: begin
					delay_timer_enable = 3'h1;
				end
				hall_pkg::TMR_ONE: begin
					delay_timer_enable = 3'h2;
				end
				hall_pkg::TMR_THREE: begin
					delay_timer_enable = 3'h4;
				end
				// code 11 is unused: no timer is claimed
				default: begin
					delay_timer_enable = 3'h0;
				end
			endcase
		end
	end

	// single-cycle reads leave no room for wait states; none needed
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = s_q.rdata;
	assign filtered_phase = s_q.filt;
	assign phase_irq = s_q.irq;
	assign delay_path_select = s_q.cfg.decoder_ctrl[hall_pkg::BIT_DELAY_PATH];
	assign gate = s_q.gate;
endmodule

`default_nettype wire

// *** pkg/hall_pkg.sv ***
// hall_pkg: register map, field positions, reset values and carrier types
// assumes: one 40 MHz clock, APB register access with 32-bit data
package hall_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	localparam logic [11:0] OFS_SOURCE_EDGE = 12'h000;
	localparam logic [11:0] OFS_DECODER_CTRL = 12'h004;
	localparam logic [11:0] OFS_SOFT_PHASE = 12'h008;
	localparam logic [11:0] OFS_CHECK_COUNT = 12'h00C;
	localparam logic [11:0] OFS_FILTER_MODE = 12'h010;
	localparam logic [11:0] OFS_STATUS = 12'h014;
	localparam logic [11:0] OFS_TABLE_BASE = 12'h040;
	localparam int unsigned TABLE_ENTRIES = 12;
	localparam int unsigned BACKWARD_BASE = 6;
	localparam logic [7:0] RST_SOURCE_EDGE = 8'h00;
	localparam logic [7:0] RST_DECODER_CTRL = 8'h10;
	localparam logic [7:0] RST_SOFT_PHASE = 8'h00;
	localparam logic [7:0] RST_CHECK_COUNT = 8'h00;
	localparam logic [7:0] RST_FILTER_MODE = 8'h00;
	localparam logic [5:0] RST_TABLE = 6'h00;
	localparam logic [7:0] MASK_SOURCE_EDGE = 8'h7F;
	localparam logic [7:0] MASK_SOFT_PHASE = 8'h07;
	localparam logic [7:0] MASK_CHECK_COUNT = 8'h1F;
	localparam logic [7:0] MASK_FILTER_MODE = 8'h0F;
	localparam logic [7:0] MASK_TABLE = 8'h3F;
	localparam int unsigned BIT_DECODER_ENABLE = 0;
	localparam int unsigned BIT_DIRECTION = 1;
	localparam int unsigned BIT_BRAKE = 2;
	localparam int unsigned BIT_INPUT_MODE = 3;
	localparam int unsigned BIT_ANGLE = 4;
	localparam int unsigned BIT_DELAY_PATH = 5;
	localparam int unsigned POS_TIMER_SEL = 6;
	localparam int unsigned BIT_SOURCE_SEL = 6;
	localparam int unsigned BIT_FILTER_ENABLE = 3;
	localparam logic [2:0] FILTER_CLK_UNUSED = 3'h7;
	localparam logic [5:0] PATTERN_OFF = 6'h00;
	localparam logic [5:0] PATTERN_BRAKE = 6'h15;
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [1:0] TMR_ZERO = 2'h0;
	localparam logic [1:0] TMR_ONE = 2'h1;
	localparam logic [1:0] TMR_THREE = 2'h2;

	typedef struct packed {
		logic [7:0] source_edge;
		logic [7:0] decoder_ctrl;
		logic [7:0] soft_phase;
		logic [7:0] check_count;
		logic [7:0] filter_mode;
	} config_t;

	typedef struct packed {
		logic gate_a_high;
		logic gate_a_low;
		logic gate_b_high;
		logic gate_b_low;
		logic gate_c_high;
		logic gate_c_low;
	} gate_t;
endpackage

// *** tb/hall_sensor_model.sv ***
// hall_sensor_model: three motor hall sensors plus the comparator outputs
// assumes: bench sets rotor position on pos; comparators read inverted
`timescale 1ns/1ps
`default_nettype none
module hall_sensor_model (
	input wire logic clk,
	input wire logic [2:0] pos,
	output logic [2:0] hall_pin,
	output logic [2:0] comparator_out
);
	// inverted comparators make the source switch visible on the filtered phases
	always_ff @(posedge clk) begin
		hall_pin <= pos;
		comparator_out <= ~pos;
	end
endmodule
`default_nettype wire

// *** tb/hall_commutation_decoder_asserts.sv ***
// checker: port-level properties of the hall commutation decoder
// assumes: bound into hall_commutation_decoder, synchronous high rst
`timescale 1ns/1ps
`default_nettype none
module hall_commutation_decoder_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic [2:0] phase_irq,
	input wire logic [2:0] delay_timer_enable,
	input wire logic delay_path_select,
	input wire hall_pkg::gate_t gate
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence ctrl_wr;
		psel && penable && pwrite && paddr == hall_pkg::OFS_DECODER_CTRL;
	endsequence
	sequence rd_setup;
		psel && !penable && !pwrite;
	endsequence
	brake_force_a: assert property (ctrl_wr ##0 pwdata[2] |=> ##1 gate == 6'h15)
		else $error("brake pattern missing");
	free_run_a: assert property (ctrl_wr ##0 !pwdata[2] && !pwdata[0] |=> ##1 gate == 6'h00)
		else $error("free run pattern missing");
	soft_read_a: assert property (rd_setup ##0 paddr == 12'h008 |=> prdata[31:3] == 29'h0)
		else $error("soft phase upper bits set");
	table_read_a: assert property (rd_setup ##0 paddr >= 12'h040 |=> prdata[31:6] == 26'h0)
		else $error("table upper bits set");
	irq_pulse_a: assert property (phase_irq[0] |=> !phase_irq[0])
		else $error("irq longer than one cycle");
	timer_path_a: assert property (delay_timer_enable != 3'h0 |-> delay_path_select)
		else $error("timer enabled without delay path");
	timer_onehot_a: assert property ($onehot0(delay_timer_enable))
		else $error("several delay timers enabled");
	reset_gate_a: assert property ($fell(rst) |-> gate == 6'h00)
		else $error("gate not off after reset");
endmodule
bind hall_commutation_decoder hall_commutation_decoder_asserts checker_inst (.clk, .rst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .phase_irq, .delay_timer_enable,
	.delay_path_select, .gate);
`default_nettype wire

// *** tb/testbench.sv ***
// testbench: registers, decode tables, filter, edges and delay path
// assumes: sensor model on the pins, checker bound in its own file
`timescale 1ns/1ps
`default_nettype none
`define chk(a, e) begin checked++; if ((a) !== (e)) begin fails++; $display("Error %0t: value mismatch", $time); end end
module testbench;
	logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, dps;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic [2:0] pos = 3'h0, dly = 3'h0, hp, co, fp, irq, dte;
	hall_pkg::gate_t gate;
	int fails = 0, checked = 0;
	hall_sensor_model hall_sensor_model_inst (.clk(clk), .pos(pos), .hall_pin(hp), .comparator_out(co));
	hall_commutation_decoder hall_commutation_decoder_inst (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hall_pin(hp), .comparator_out(co), .delayed_phase(dly),
		.filtered_phase(fp), .phase_irq(irq), .delay_timer_enable(dte), .delay_path_select(dps),
		.gate(gate));
	initial forever #12.5 clk = ~clk;
	task automatic stop_test;
		if (fails == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rd = prdata;
		`chk(pslverr, 1'h0)
		if (pready !== 1'h1) begin
			fails++;
			$display("Error %0t: no pready", $time);
			stop_test();
		end
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic sg(input logic [2:0] s, input logic [5:0] e);
		apb(1'h1, 12'h008, {29'h0, s});
		cyc(2);
		`chk(gate, e)
	endtask
	task automatic t_regs;
		logic [11:0] a[6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h040};
		logic [7:0] r[6] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
		logic [7:0] m[6] = '{8'h7F, 8'hFF, 8'h07, 8'h1F, 8'h0F, 8'h3F};
		for (int i = 0; i < 7; i++) begin
			apb(1'h0, i < 6 ? a[i] : 12'h020, 32'h0);
			`chk(rd, {24'h0, i < 6 ? r[i] : 8'h00})
			apb(1'h1, i < 6 ? a[i] : 12'h020, 32'hFFFFFFFF);
			apb(1'h0, i < 6 ? a[i] : 12'h020, 32'h0);
			`chk(rd, {24'h0, i < 6 ? m[i] : 8'h00})
			apb(1'h1, i < 6 ? a[i] : 12'h020, {24'h0, i < 6 ? r[i] : 8'h00});
		end
	endtask
	task automatic t_table;
		logic [2:0] s[2][6] = '{'{3'h1, 3'h3, 3'h7, 3'h6, 3'h4, 3'h0},
			'{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5}};
		logic [2:0] bad[2][2] = '{'{3'h5, 3'h2}, '{3'h7, 3'h0}};
		// tables written before the decoder is enabled
		for (int n = 0; n < 12; n++) begin
			apb(1'h1, 12'h040 + 12'(4 * n), 32'(n + 1));
		end
		for (int m = 0; m < 2; m++) begin
			for (int d = 0; d < 2; d++) begin
				apb(1'h1, 12'h004, 32'(16 * m + 2 * d + 1));
				for (int i = 0; i < 6; i++) begin
					sg(s[m][i], 6'(6 * d + i + 1));
				end
				sg(bad[m][0], 6'h00);
				sg(bad[m][1], 6'h00);
			end
			apb(1'h1, 12'h004, 32'(16 * m + 5));
			sg(s[m][2], 6'h15);
			apb(1'h1, 12'h004, 32'(16 * m));
			sg(s[m][0], 6'h00);
		end
	endtask
	task automatic t_filter;
		int cnt;
		apb(1'h1, 12'h004, 32'h00000018);
		pos <= 3'h1;
		cyc(8);
		`chk(fp, 3'h1)
		apb(1'h1, 12'h000, 32'h00000040);
		cyc(8);
		`chk(fp, 3'h6)
		for (int c = 0; c < 4; c++) begin
			apb(1'h1, 12'h000, 32'(c));
			pos <= 3'h0;
			cyc(10);
			cnt = 0;
			pos <= 3'h1;
			for (int k = 0; k < 24; k++) begin
				@(posedge clk);
				cnt += (irq[0] === 1'h1);
				if (k == 11) pos <= 3'h0;
			end
			`chk(cnt, c == 3 ? 2 : (c == 0 ? 0 : 1))
		end
		// slow count so a new level on the pin is held back for several samples
		apb(1'h1, 12'h00C, 32'h00000008);
		apb(1'h1, 12'h010, 32'h00000008);
		pos <= 3'h1;
		cyc(10);
		`chk(fp, 3'h0)
		cyc(20);
		`chk(fp, 3'h1)
	endtask
	task automatic t_delay;
		apb(1'h1, 12'h010, 32'h0);
		pos <= 3'h3;
		dly <= 3'h1;
		for (int t = 0; t < 4; t++) begin
			apb(1'h1, 12'h004, 32'(64 * t + 57));
			cyc(3);
			`chk(dte, t == 3 ? 3'h0 : 3'(1 << t))
			`chk(gate, 6'h01)
			`chk(dps, 1'h1)
		end
		apb(1'h1, 12'h004, 32'h00000019);
		cyc(3);
		`chk(dte, 3'h0)
		`chk(dps, 1'h0)
		`chk(gate, 6'h02)
	endtask
	initial begin
		cyc(10);
		rst <= 1'h0;
		t_regs();
		t_table();
		t_filter();
		t_delay();
		stop_test();
	end
endmodule
`default_nettype wire
